/* File: rtl/cpdtf_pkg.sv */
/*
 Constants shared by the transceiver protection logic and its event FIFO.
 Assumes a 250 MHz core clock; every period is timed on a 1 us tick.
*/
package cpdtf_pkg;
	// Clock and timebase
	localparam int CLK_NS       = 4;
	localparam int TICK_NS      = 1000;
	localparam int TICK_CYCLES  = TICK_NS / CLK_NS;
	localparam int TICK_W       = 8;
	localparam int TMR_W        = 12;

	// Transmit stuck timeout window and nominal period, in us
	localparam int TX_MIN_US    = 1175;
	localparam int TX_MAX_US    = 3700;
	localparam int TX_PERIOD_US = 2000;
	localparam int TX_TICKS     = TX_PERIOD_US * 1000 / TICK_NS;

	// Receive stuck timeout window and nominal period, in us
	localparam int RX_MIN_US    = 1380;
	localparam int RX_MAX_US    = 4200;
	localparam int RX_PERIOD_US = 2500;
	localparam int RX_TICKS     = RX_PERIOD_US * 1000 / TICK_NS;

	// Supply recovery delay, in us
	localparam int UV_DELAY_US  = 300;
	localparam int UV_TICKS     = UV_DELAY_US * 1000 / TICK_NS;

	// Fault event word layout
	localparam int EV_W         = 4;
	localparam int EV_DEPTH     = 16;
	localparam int EV_TX        = 0;
	localparam int EV_RX        = 1;
	localparam int EV_OT        = 2;
	localparam int EV_UV        = 3;

	// Reset values
	localparam logic [2:0]      SYNC_RST = 3'h7;
	localparam logic [EV_W-1:0] EV_RST   = 4'h0;

	// Supply supervisor states
	typedef enum logic [1:0] {
		SUP_PROT = 2'b00,
		SUP_WAIT = 2'b01,
		SUP_RUN  = 2'b10
	} cpdtf_sup_t;
endpackage

/* File: rtl/cpdtf_fifo.sv */
/*
 Small FIFO with valid/ready on both sides and a registered read word.
 Assumes one clock; the drain side may stall for as long as it likes.
*/
`timescale 1ns/1ps
module cpdtf_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,  // Core clock
	input  wire logic             rst_b,     // Async reset, active low
	input  wire logic             in_valid,  // Word offered
	output logic                  in_ready,  // Room for a word
	input  wire logic [WIDTH-1:0] in_data,   // Word in
	output logic                  out_valid, // Word held at output
	input  wire logic             out_ready, // Drain takes word
	output logic      [WIDTH-1:0] out_data   // Registered word out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	// Handshake terms
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign push     = in_valid & in_ready;
	assign pop      = (count != '0) & (~out_valid | out_ready);

	// Storage, no reset needed
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

	// Output register stage
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data  <= mem[rd_ptr];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule

/* File: rtl/cpdtf_top.sv */
/*
 Digital protection core of a high-speed CAN transceiver: transmit and
 receive stuck-dominant timeouts, thermal and supply shutdown, fault flag,
 and a FIFO log of fault onsets.
 Assumes all pin inputs are asynchronous to core_clk; the analog driver
 and receiver sit outside and obey the drive and bias outputs.
*/
`timescale 1ns/1ps
// Operation
// - Transmit timeout only acts in normal mode
// - Transmit falling edge starts transmit timer
// - Timer expiry with no rise disables driver
// - Recessive transmit input clears timeout, re-enables
// - Receive output follows bus; bus recessive bias
// - Receive falling edge starts receive timer
// - Receive expiry forces receive output high
// - Recessive bus clears receive timeout, mirrors again
// - Over-temperature turns driver off, receiver stays
// - Single supply bad: bus and receive tri-stated
// - Dual supply: per-rail bus and receive states
// - Supplies good again: resume after 300 us
// - Fault output released while any fault active
// - Transmit period within 1175 to 3700 us
// - Receive period within 1380 to 4200 us
// - Mode low normal, high silent, receiver on
// - Dominant is logic low, recessive logic high
module cpdtf_top #(
	parameter bit                         HAS_RX_TIMEOUT = 1'b1,
	parameter bit                         DUAL_SUPPLY    = 1'b0,
	parameter logic [cpdtf_pkg::TICK_W-1:0] TICK_CYCLES =
		cpdtf_pkg::TICK_W'(cpdtf_pkg::TICK_CYCLES),
	parameter logic [cpdtf_pkg::TMR_W-1:0]  TX_TICKS =
		cpdtf_pkg::TMR_W'(cpdtf_pkg::TX_TICKS),
	parameter logic [cpdtf_pkg::TMR_W-1:0]  RX_TICKS =
		cpdtf_pkg::TMR_W'(cpdtf_pkg::RX_TICKS),
	parameter logic [cpdtf_pkg::TMR_W-1:0]  UV_TICKS =
		cpdtf_pkg::TMR_W'(cpdtf_pkg::UV_TICKS),
	parameter int                         EV_DEPTH = cpdtf_pkg::EV_DEPTH
) (
	input  wire logic                       core_clk,     // 250 MHz core clock
	input  wire logic                       rst_b,        // Async reset, active low
	input  wire logic                       txd_in,       // Transmit input, low dominant
	input  wire logic                       silent_in,    // Mode select, high silent
	input  wire logic                       bus_rx_in,    // Receiver comparator, low dominant
	input  wire logic                       overtemp_in,  // Over-temperature, high active
	input  wire logic                       vcc_good_in,  // Main supply good
	input  wire logic                       vio_good_in,  // I/O supply good
	output logic                            drv_dominant, // Drive bus dominant
	output logic                            bus_hiz,      // Bus outputs high impedance
	output logic                            rxd_out,      // Receive output level
	output logic                            rxd_oe,       // Receive output driven
	output logic                            fault_out,    // Fault pin level, always low
	output logic                            fault_oe,     // Fault pin pulled low
	output logic                            ev_valid,     // Fault event word ready
	input  wire logic                       ev_ready,     // Event word taken
	output logic [cpdtf_pkg::EV_W-1:0]      ev_data       // Fault onset bits
);
	localparam int NSYNC = 6;
	localparam int S_TX  = 0;
	localparam int S_SIL = 1;
	localparam int S_RX  = 2;
	localparam int S_OT  = 3;
	localparam int S_VCC = 4;
	localparam int S_VIO = 5;

	logic [NSYNC-1:0]                 pin_raw;
	logic [NSYNC-1:0]                 pin_f;
	logic [cpdtf_pkg::TICK_W-1:0]     tick_cnt;
	logic                             tick;
	logic                             tx_f;
	logic                             silent_f;
	logic                             rx_f;
	logic                             ot_f;
	logic                             vcc_f;
	logic                             vio_f;
	logic                             tx_prev;
	logic                             rx_prev;
	logic                             tx_fall;
	logic                             rx_fall;
	logic                             tx_run;
	logic                             rx_run;
	logic [cpdtf_pkg::TMR_W-1:0]      tx_cnt;
	logic [cpdtf_pkg::TMR_W-1:0]      rx_cnt;
	logic                             tx_to;
	logic                             rx_to;
	logic                             supply_ok;
	logic                             protected_st;
	cpdtf_pkg::cpdtf_sup_t            sup_state;
	logic [cpdtf_pkg::TMR_W-1:0]      uv_cnt;
	logic [cpdtf_pkg::EV_W-1:0]       cause;
	logic [cpdtf_pkg::EV_W-1:0]       cause_prev;
	logic [cpdtf_pkg::EV_W-1:0]       pending;
	logic [cpdtf_pkg::EV_W-1:0]       next_pending;
	logic                             ev_in_ready;
	logic                             ev_push;

	assign pin_raw = {vio_good_in, vcc_good_in, overtemp_in,
			bus_rx_in, silent_in, txd_in};

	// Three-stage synchronisers with agreement filter
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			logic [2:0] st;
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					st          <= cpdtf_pkg::SYNC_RST;
					pin_f[gi]   <= 1'b1;
				end else begin
					st <= {st[1:0], pin_raw[gi]};
					if (st[1] == st[2]) begin
						pin_f[gi] <= st[2];
					end
				end
			end
		end
	endgenerate

	assign tx_f     = pin_f[S_TX];
	assign silent_f = pin_f[S_SIL];
	assign rx_f     = pin_f[S_RX];
	assign ot_f     = pin_f[S_OT];
	assign vcc_f    = pin_f[S_VCC];
	assign vio_f    = DUAL_SUPPLY ? pin_f[S_VIO] : 1'b1;

	// Free-running 1 us timebase
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else if (tick_cnt == TICK_CYCLES - 1'b1) begin
			tick_cnt <= '0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			tick     <= 1'b0;
		end
	end

	// Edge detection on filtered levels, low is dominant
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_prev <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			tx_prev <= tx_f;
			rx_prev <= rx_f;
		end
	end
	assign tx_fall = tx_prev & ~tx_f;
	assign rx_fall = rx_prev & ~rx_f;

	// Transmit stuck timer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_run <= 1'b0;
			tx_cnt <= '0;
			tx_to  <= 1'b0;
		end else if (silent_f || tx_f) begin
			tx_run <= 1'b0;
			tx_cnt <= '0;
			tx_to  <= 1'b0;
		end else if (tx_fall) begin
			tx_run <= 1'b1;
			tx_cnt <= '0;
		end else if (tx_run && tick) begin
			if (tx_cnt == TX_TICKS - 1'b1) begin
				tx_run <= 1'b0;
				tx_to  <= 1'b1;
			end else begin
				tx_cnt <= tx_cnt + 1'b1;
			end
		end
	end

	// Receive stuck timer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_run <= 1'b0;
			rx_cnt <= '0;
			rx_to  <= 1'b0;
		end else if (!HAS_RX_TIMEOUT || rx_f) begin
			rx_run <= 1'b0;
			rx_cnt <= '0;
			rx_to  <= 1'b0;
		end else if (rx_fall) begin
			rx_run <= 1'b1;
			rx_cnt <= '0;
		end else if (rx_run && tick) begin
			if (rx_cnt == RX_TICKS - 1'b1) begin
				rx_run <= 1'b0;
				rx_to  <= 1'b1;
			end else begin
				rx_cnt <= rx_cnt + 1'b1;
			end
		end
	end

	// Supply supervisor with recovery delay
	assign supply_ok    = vcc_f & vio_f;
	assign protected_st = (sup_state != cpdtf_pkg::SUP_RUN);
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sup_state <= cpdtf_pkg::SUP_PROT;
			uv_cnt    <= '0;
		end else if (!supply_ok) begin
			sup_state <= cpdtf_pkg::SUP_PROT;
			uv_cnt    <= '0;
		end else begin
			case (sup_state)
				cpdtf_pkg::SUP_PROT: begin
					sup_state <= cpdtf_pkg::SUP_WAIT;
					uv_cnt    <= '0;
				end
				cpdtf_pkg::SUP_WAIT: begin
					if (uv_cnt == UV_TICKS) begin
						sup_state <= cpdtf_pkg::SUP_RUN;
					end else if (tick) begin
						uv_cnt <= uv_cnt + 1'b1;
					end
				end
				cpdtf_pkg::SUP_RUN: begin
					sup_state <= cpdtf_pkg::SUP_RUN;
				end
				default: begin
					sup_state <= cpdtf_pkg::SUP_PROT;
				end
			endcase
		end
	end

	// Bus driver and bias control
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			drv_dominant <= 1'b0;
			bus_hiz      <= 1'b1;
		end else begin
			// Dominant only in normal mode, healthy, input low
			drv_dominant <= ~silent_f & ~tx_to & ~ot_f
				& ~protected_st & ~tx_f;
			if (DUAL_SUPPLY) begin
				bus_hiz <= protected_st & ~(vcc_f & ~vio_f);
			end else begin
				bus_hiz <= protected_st;
			end
		end
	end

	// Receive output path
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxd_out <= 1'b1;
			rxd_oe  <= 1'b0;
		end else if (protected_st) begin
			rxd_out <= 1'b1;
			rxd_oe  <= DUAL_SUPPLY & vio_f;
		end else begin
			rxd_out <= rx_f | rx_to;
			rxd_oe  <= 1'b1;
		end
	end

	// Open-drain fault flag
	assign cause = {protected_st, ot_f, rx_to, tx_to};
	assign fault_out = 1'b0;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fault_oe <= 1'b0;
		end else begin
			fault_oe <= ~(|cause);
		end
	end

	// Fault onset capture, new onsets win over the push clear
	always_comb begin
		next_pending = ev_push ? '0 : pending;
		next_pending = next_pending | (cause & ~cause_prev);
	end
	assign ev_push = (|pending) & ev_in_ready;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cause_prev <= cpdtf_pkg::EV_RST;
			pending    <= cpdtf_pkg::EV_RST;
		end else begin
			cause_prev <= cause;
			pending    <= next_pending;
		end
	end

	// Event log FIFO, stalls capture when full
	cpdtf_fifo #(
		.WIDTH (cpdtf_pkg::EV_W),
		.DEPTH (EV_DEPTH)
	) u_ev_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.in_valid  (|pending),
		.in_ready  (ev_in_ready),
		.in_data   (pending),
		.out_valid (ev_valid),
		.out_ready (ev_ready),
		.out_data  (ev_data)
	);

	// Checks on the protection behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_tx_fall;
		tx_fall && !silent_f;
	endsequence

	sequence s_tx_armed;
		tx_run && (tx_cnt == '0);
	endsequence

	a_tx_start_arm: assert property (s_tx_fall |=> s_tx_armed)
		else $error("transmit timer not armed on falling edge");

	a_tx_expiry_cut: assert property (
		$rose(tx_to) |-> !tx_f && !silent_f ##1 !drv_dominant)
		else $error("driver still active after transmit timeout");

	a_tx_clear_high: assert property (tx_to && tx_f |=> !tx_to)
		else $error("transmit timeout not cleared by recessive input");

	a_silent_no_drv: assert property (silent_f |=> !drv_dominant)
		else $error("driver active in silent mode");

	a_rx_force_high: assert property (
		rx_to && !protected_st |=> rxd_out && rxd_oe)
		else $error("receive output not forced high on timeout");

	a_rx_mirror_bus: assert property (
		!rx_to && !protected_st |=> rxd_out == $past(rx_f))
		else $error("receive output does not mirror bus");

	a_ot_drv_off: assert property (
		ot_f && !protected_st |=> !drv_dominant && rxd_oe)
		else $error("over-temperature did not stop driver");

	a_fault_release: assert property (
		(tx_to || rx_to || ot_f || protected_st) |=> !fault_oe)
		else $error("fault pin not released on fault");

	a_fault_return: assert property (
		!(tx_to || rx_to || ot_f || protected_st) |=> fault_oe)
		else $error("fault pin not pulled low after clear");

	a_uv_delay_done: assert property (
		$fell(protected_st) |-> $past(uv_cnt) == UV_TICKS)
		else $error("supply recovery delay not honoured");

	a_uv_bus_off: assert property (
		!supply_ok |=> protected_st ##1 !drv_dominant)
		else $error("driver active during undervoltage");
endmodule

/* File: tb/cpdtf_ctrl_model.sv */
/*
 Behavioural protocol controller on the logic side of the transceiver.
 Assumes the bench calls its tasks; the transmit line idles recessive.
*/
`timescale 1ns/1ps
module cpdtf_ctrl_model (
	input  wire logic core_clk, // Core clock
	input  wire logic rxd_out,  // Receive output level
	input  wire logic rxd_oe,   // Receive output driven
	output logic      txd,      // Transmit line, low dominant
	output logic      rx_seen   // Last driven receive level
);
	// Idle recessive until told otherwise
	initial txd = 1'b1;
	initial rx_seen = 1'b1;

	// Capture the receive level only while the pin is driven
	always_ff @(posedge core_clk) begin
		if (rxd_oe) begin
			rx_seen <= rxd_out;
		end
	end

	// Change the transmit level at a clock edge
	task automatic tx_level(input logic lvl);
		@(posedge core_clk);
		txd <= lvl;
	endtask

	// Worst legal run of eleven dominant bits, kept below the timeout
	task automatic frame_dominant(input int bit_cycles);
		tx_level(1'b0);
		repeat (11 * bit_cycles) @(posedge core_clk);
		txd <= 1'b1;
	endtask
endmodule

/* File: tb/testbench.sv */
/*
 Self-checking bench for the transceiver protection core.
 Assumes short timer parameters: 4-cycle tick, 20/25/5 tick periods.
*/
`timescale 1ns/1ps
module testbench;
	logic       core_clk;
	logic       rst_b;
	logic       txd_in;
	logic       silent_in;
	logic       bus_rx_in;
	logic       overtemp_in;
	logic       vcc_good_in;
	logic       vio_good_in;
	logic       drv_dominant;
	logic       bus_hiz;
	logic       rxd_out;
	logic       rxd_oe;
	logic       fault_out;
	logic       fault_oe;
	logic       ev_valid;
	logic       ev_ready;
	logic       rx_seen;
	logic [3:0] ev_data;
	int         failures;
	int         comparisons;

	cpdtf_top #(
		.TICK_CYCLES (8'h04),
		.TX_TICKS    (12'h014),
		.RX_TICKS    (12'h019),
		.UV_TICKS    (12'h005)
	) dut (
		.core_clk     (core_clk),
		.rst_b        (rst_b),
		.txd_in       (txd_in),
		.silent_in    (silent_in),
		.bus_rx_in    (bus_rx_in),
		.overtemp_in  (overtemp_in),
		.vcc_good_in  (vcc_good_in),
		.vio_good_in  (vio_good_in),
		.drv_dominant (drv_dominant),
		.bus_hiz      (bus_hiz),
		.rxd_out      (rxd_out),
		.rxd_oe       (rxd_oe),
		.fault_out    (fault_out),
		.fault_oe     (fault_oe),
		.ev_valid     (ev_valid),
		.ev_ready     (ev_ready),
		.ev_data      (ev_data)
	);

	cpdtf_ctrl_model ctrl (
		.core_clk (core_clk),
		.rxd_out  (rxd_out),
		.rxd_oe   (rxd_oe),
		.txd      (txd_in),
		.rx_seen  (rx_seen)
	);

	// Clock at 4 ns
	initial core_clk = 1'b0;
	always #2 core_clk = ~core_clk;

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Compare one-bit results just after the edge
	task automatic chk_bit(input string name, input logic exp, input logic got);
		#1;
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s expected %b seen %b", name, exp, got);
		end
	endtask

	// Compare event words
	task automatic chk_word(input string name, input logic [3:0] exp, input logic [3:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic summarize;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Legal frame passes and the receive output mirrors the bus
	task automatic t_frame;
		fork
			ctrl.frame_dominant(4);
			begin
				cyc(2);
				bus_rx_in <= 1'b0;
				cyc(10);
				chk_bit("drv in frame", 1'b1, drv_dominant);
				chk_bit("rxd in frame", 1'b0, rxd_out);
				chk_bit("fault in frame", 1'b1, fault_oe);
			end
		join
		cyc(1);
		bus_rx_in <= 1'b1;
		cyc(10);
		chk_bit("drv after frame", 1'b0, drv_dominant);
	endtask

	// Stuck transmit input is cut off, then cleared by recessive
	task automatic t_txto;
		ctrl.tx_level(1'b0);
		cyc(60);
		chk_bit("drv before timeout", 1'b1, drv_dominant);
		cyc(40);
		bus_rx_in <= 1'b0;
		chk_bit("drv timed out", 1'b0, drv_dominant);
		chk_bit("bias in timeout", 1'b0, bus_hiz);
		chk_bit("fault tx", 1'b0, fault_oe);
		chk_bit("fault level", 1'b0, fault_out);
		cyc(10);
		chk_bit("rxd in timeout", 1'b0, rxd_out);
		bus_rx_in <= 1'b1;
		ctrl.tx_level(1'b1);
		cyc(10);
		chk_bit("fault tx cleared", 1'b1, fault_oe);
		ctrl.tx_level(1'b0);
		cyc(10);
		chk_bit("drv again", 1'b1, drv_dominant);
		ctrl.tx_level(1'b1);
		cyc(10);
	endtask

	// Silent mode keeps the driver off and the timer clear
	task automatic t_silent;
		silent_in <= 1'b1;
		ctrl.tx_level(1'b0);
		cyc(10);
		chk_bit("drv silent", 1'b0, drv_dominant);
		cyc(110);
		chk_bit("fault silent", 1'b1, fault_oe);
		silent_in <= 1'b0;
		ctrl.tx_level(1'b1);
		cyc(10);
	endtask

	// Stuck dominant bus releases the receive output
	task automatic t_rxto;
		bus_rx_in <= 1'b0;
		cyc(80);
		chk_bit("rxd before timeout", 1'b0, rxd_out);
		cyc(50);
		chk_bit("rxd timed out", 1'b1, rxd_out);
		chk_bit("fault rx", 1'b0, fault_oe);
		bus_rx_in <= 1'b1;
		cyc(10);
		chk_bit("fault rx cleared", 1'b1, fault_oe);
		bus_rx_in <= 1'b0;
		cyc(10);
		chk_bit("rxd mirrors", 1'b0, rxd_out);
		chk_bit("rxd seen by ctrl", 1'b0, rx_seen);
		bus_rx_in <= 1'b1;
		cyc(10);
	endtask

	// Over-temperature stops the driver but not the receiver
	task automatic t_ot;
		ctrl.tx_level(1'b0);
		bus_rx_in <= 1'b0;
		cyc(10);
		overtemp_in <= 1'b1;
		cyc(10);
		chk_bit("drv hot", 1'b0, drv_dominant);
		chk_bit("bias hot", 1'b0, bus_hiz);
		chk_bit("rxd hot", 1'b0, rxd_out);
		chk_bit("fault hot", 1'b0, fault_oe);
		overtemp_in <= 1'b0;
		cyc(10);
		chk_bit("drv cooled", 1'b1, drv_dominant);
		chk_bit("fault cooled", 1'b1, fault_oe);
		ctrl.tx_level(1'b1);
		bus_rx_in <= 1'b1;
		cyc(10);
	endtask

	// Supply loss protects, recovery waits before resuming
	task automatic t_uv;
		vcc_good_in <= 1'b0;
		cyc(10);
		chk_bit("hiz bad supply", 1'b1, bus_hiz);
		chk_bit("rxd tristate", 1'b0, rxd_oe);
		chk_bit("fault supply", 1'b0, fault_oe);
		vcc_good_in <= 1'b1;
		cyc(10);
		chk_bit("hiz recovering", 1'b1, bus_hiz);
		cyc(30);
		chk_bit("hiz resumed", 1'b0, bus_hiz);
		chk_bit("rxd driven", 1'b1, rxd_oe);
		chk_bit("fault resumed", 1'b1, fault_oe);
		// Single supply build ignores the I/O rail
		vio_good_in <= 1'b0;
		cyc(10);
		chk_bit("hiz io rail low", 1'b0, bus_hiz);
		chk_bit("fault io rail low", 1'b1, fault_oe);
		vio_good_in <= 1'b1;
		cyc(10);
	endtask

	// Fill the event log while stalled, then drain it empty
	task automatic t_fifo;
		int cnt;
		cnt = 0;
		cyc(1);
		chk_bit("log empty", 1'b0, ev_valid);
		ev_ready <= 1'b0;
		repeat (20) begin
			cyc(1);
			overtemp_in <= 1'b1;
			cyc(8);
			overtemp_in <= 1'b0;
			cyc(7);
		end
		cyc(10);
		ev_ready <= 1'b1;
		#1;
		for (int i = 0; i < 40; i++) begin
			if (ev_valid === 1'b1) begin
				cnt++;
				chk_word("event word", 4'h4, ev_data);
			end
			@(posedge core_clk);
			#1;
		end
		// Sixteen stored, one held at output, one pending merged
		chk_word("event count ok", 4'h1, {3'h0, cnt >= 17 && cnt <= 18});
		chk_bit("log drained", 1'b0, ev_valid);
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		summarize();
	end

	// Main sequence
	initial begin
		failures = 0;
		comparisons = 0;
		rst_b = 1'b0;
		silent_in = 1'b0;
		bus_rx_in = 1'b1;
		overtemp_in = 1'b0;
		vcc_good_in = 1'b1;
		vio_good_in = 1'b1;
		ev_ready = 1'b1;
		cyc(10);
		rst_b <= 1'b1;
		cyc(60);
		t_frame();
		t_txto();
		t_silent();
		t_rxto();
		t_ot();
		t_uv();
		t_fifo();
		summarize();
	end
endmodule
